// *** src/ssfac_top.sv ***
`include "ssfac_regs.svh"
module ssfac_top
   import ssfac_pkg::*;
#(
   parameter int CONV_CYC = `SSFAC_CONV_CYC
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_out_o,
   output logic sda_oe_n_o,
   output logic alert_out_o,
   output logic alert_oe_n_o,
   input wire logic on_pin_i,
   input wire logic card_present_n_i,
   input wire logic internal_supply_uvlo_i,
   input wire logic gpio1_i,
   input wire logic [3:0] uv_cond_i,
   input wire logic [3:0] oc_cond_i,
   input wire logic [3:0] pb_cond_i,
   input wire logic pgi_cond_i,
   input wire logic fet_short_cond_i,
   input wire logic oc_cooldown_i,
   input wire logic pgi_cooldown_i,
   input wire logic addr_strap_0_i,
   input wire logic addr_strap_1_i,
   input wire logic [1:0] addr_strap_2_i,
   input wire logic [1:0] addr_strap_3_i,
   input wire logic [7:0] adc_result_i,
   output logic [3:0] adc_channel_o,
   output logic [1:0] adc_gpio_sel_o,
   output logic switch_permit_o
);
   function automatic logic is_ch(input logic [4:0] a);
      return (a >= `SSFAC_A_DATA0) && (a < `SSFAC_A_DATA0 + 5'(`SSFAC_NUM_CH));
   endfunction : is_ch

   // Sticky fault update: hold terms and new events win over any clear
   function automatic logic [7:0] fault_upd(input logic [7:0] old, input logic [7:0] set,
      input logic [7:0] keep, input logic [7:0] clr, input logic [7:0] wmask);
      return (old & ~clr & wmask) | set | (old & keep);
   endfunction : fault_upd

   logic [27:0] pins_s;
   ssfac_sync #(.W(28)) u_sync (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .d_i({scl_i, sda_i, on_pin_i, card_present_n_i, internal_supply_uvlo_i, gpio1_i,
            uv_cond_i, oc_cond_i, pb_cond_i, pgi_cond_i, fet_short_cond_i, oc_cooldown_i,
            pgi_cooldown_i, addr_strap_0_i, addr_strap_1_i, addr_strap_2_i, addr_strap_3_i}),
      .q_o(pins_s)
   );
   wire scl_s = pins_s[27];
   wire sda_s = pins_s[26];
   wire on_s = pins_s[25];
   wire card_s = pins_s[24];
   wire uvlo_s = pins_s[23];
   wire gpio_s = pins_s[22];
   wire [3:0] uv_s = pins_s[21:18];
   wire [3:0] oc_s = pins_s[17:14];
   wire [3:0] pb_s = pins_s[13:10];
   wire pgi_s = pins_s[9];
   wire fet_s = pins_s[8];
   wire oc_cool_s = pins_s[7];
   wire pgi_cool_s = pins_s[6];
   wire [5:0] strap_s = pins_s[5:0];

   logic [7:0] alert_en_reg;
   logic [7:0] ctrl_reg;
   logic [7:0] on_reg;
   logic [7:0] gpio_reg;
   logic [7:0] fault_e_reg;
   logic [7:0] fault_f_reg;
   logic [7:0] kind_reg;
   logic [7:0] adc_data_reg [0:`SSFAC_NUM_CH-1];
   logic [4:0] own_reg;
   logic [1:0] strap_done_reg;
   logic on_d_reg;
   logic card_d_reg;
   logic gpio_d_reg;
   logic permit_reg;

   ssfac_i2c_e st_reg;
   logic [7:0] sh_reg;
   logic [2:0] bcnt_reg;
   logic scl_d_reg;
   logic sda_d_reg;
   logic drv_reg;
   logic ara_reg;
   logic first_reg;
   logic acked_reg;
   logic [4:0] ptr_reg;
   logic wr_reg;
   logic [7:0] wdata_reg;
   logic ara_win_reg;

   // Three-state straps are coded 0, 1, 2; 36 codes fold onto 32 addresses
   wire [6:0] strap_idx = 7'(({3'h0, strap_s[1:0]} * 5'h3 + {3'h0, strap_s[3:2]}) * 7'h4)
                        + 7'({strap_s[4], strap_s[5]});
   wire [6:0] own_addr = {`SSFAC_ADDR_HI, own_reg};

   wire start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
   wire stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;
   wire scl_rise = scl_s && !scl_d_reg;
   wire scl_fall = !scl_s && scl_d_reg;
   wire [7:0] rx_byte = {sh_reg[6:0], sda_s};
   wire last_bit = scl_rise && (bcnt_reg == 3'h7);
   wire alert_on = alert_en_reg[`SSFAC_B_ASSERTED];
   wire hit_own = (rx_byte[7:1] == own_addr);
   wire hit_mass = (rx_byte[7:1] == `SSFAC_MASS_ADDR) && !rx_byte[0]
                 && ctrl_reg[`SSFAC_C_MASS_WR];
   wire hit_ara = (rx_byte[7:1] == `SSFAC_ARA_ADDR) && rx_byte[0] && alert_on;
   wire addr_hit = hit_own || hit_mass || hit_ara;
   wire ack_end = scl_fall && drv_reg;

   wire busy;
   wire seq_wr;
   wire [7:0] seq_data;
   wire hold = ctrl_reg[`SSFAC_C_HOLD];
   wire [3:0] dix = 4'(ptr_reg - `SSFAC_A_DATA0);
   wire wr_b = wr_reg && (ptr_reg == `SSFAC_A_ALERT);
   wire wr_c = wr_reg && (ptr_reg == `SSFAC_A_CTRL);
   wire wr_d = wr_reg && (ptr_reg == `SSFAC_A_ON);
   wire wr_e = wr_reg && (ptr_reg == `SSFAC_A_FAULT1);
   wire wr_f = wr_reg && (ptr_reg == `SSFAC_A_FAULT2);
   wire wr_g = wr_reg && (ptr_reg == `SSFAC_A_GPIO);
   wire wr_sel = wr_reg && (ptr_reg == `SSFAC_A_CHSEL);
   wire wr_dat = wr_reg && is_ch(ptr_reg) && !busy;

   wire on_fall = on_d_reg && !on_s;
   wire card_fall = card_d_reg && !card_s;
   wire card_tog = card_d_reg != card_s;
   wire gpio_tog = gpio_d_reg != gpio_s;
   wire [7:0] set_e = {oc_s, uv_s};
   wire [7:0] keep_e = {oc_s | {4{oc_cool_s}}, uv_s};
   wire [7:0] set_f = {gpio_tog, card_tog, fet_s, pgi_s, pb_s};
   wire [7:0] keep_f = {2'h0, fet_s, pgi_s | pgi_cool_s, pb_s};
   wire clr_all = on_fall || uvlo_s;
   wire [7:0] clr_e = (clr_all || card_fall) ? 8'hFF : 8'h00;
   wire [7:0] clr_f = clr_all ? 8'hFF : (card_fall ? 8'hBF : 8'h00);
   wire [7:0] e_next = fault_upd(fault_e_reg, set_e, keep_e, clr_e, wr_e ? wdata_reg : 8'hFF);
   wire [7:0] f_next = fault_upd(fault_f_reg, set_f, keep_f, clr_f, wr_f ? wdata_reg : 8'hFF);

   // Alerts follow fault kinds, so a second supply of a kind already set is silent
   wire [7:0] kind_next = {fault_f_reg[7:4], 1'b0, |fault_f_reg[3:0], |fault_e_reg[7:4],
                           |fault_e_reg[3:0]};
   wire alert_raise = |(kind_next & ~kind_reg & alert_en_reg & 8'hF7);
   wire asserted_next = alert_raise || (alert_on && !ara_win_reg
                        && !(wr_b && !wdata_reg[`SSFAC_B_ASSERTED]));
   wire permit_next = !(|fault_e_reg[3:0])
                    && !(|fault_e_reg[7:4] && !ctrl_reg[`SSFAC_C_OC_RETRY])
                    && !(fault_f_reg[`SSFAC_F_PGI] && !ctrl_reg[`SSFAC_C_PGI_RETRY]);

   wire [7:0] status = {busy, card_s, fet_s, pgi_s, 1'b0, |pb_s, |oc_s, |uv_s};
   wire [7:0] rd_byte = (ptr_reg == `SSFAC_A_STATUS) ? status
                      : (ptr_reg == `SSFAC_A_ALERT) ? alert_en_reg
                      : (ptr_reg == `SSFAC_A_CTRL) ? ctrl_reg
                      : (ptr_reg == `SSFAC_A_ON) ? on_reg
                      : (ptr_reg == `SSFAC_A_FAULT1) ? fault_e_reg
                      : (ptr_reg == `SSFAC_A_FAULT2) ? fault_f_reg
                      : (ptr_reg == `SSFAC_A_GPIO) ? gpio_reg
                      : is_ch(ptr_reg) ? adc_data_reg[dix] : 8'h00;
   // Arbitration: lowest address wins since a driven zero overrides a released one
   wire [7:0] tx_byte = ara_reg ? {own_addr, 1'b0} : rd_byte;

   assign sda_out_o = 1'b0;
   assign sda_oe_n_o = !drv_reg;
   assign alert_out_o = 1'b0;
   assign alert_oe_n_o = !alert_on;
   assign switch_permit_o = permit_reg;
   assign adc_gpio_sel_o = gpio_reg[7:6];

   ssfac_adc_seq #(.CONV_CYC(CONV_CYC), .NCH(`SSFAC_NUM_CH)) u_seq (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .hold_i(hold),
      .start_i(wr_sel),
      .start_ch_i(wdata_reg[3:0] | {4{|wdata_reg[7:4]}}),
      .result_i(adc_result_i),
      .chan_o(adc_channel_o),
      .wr_o(seq_wr),
      .wr_data_o(seq_data),
      .busy_o(busy)
   );

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         alert_en_reg <= `SSFAC_ALERT_RST;
         ctrl_reg <= `SSFAC_CTRL_RST;
         on_reg <= 8'h00;
         gpio_reg <= 8'h00;
         fault_e_reg <= 8'h00;
         fault_f_reg <= 8'h00;
         kind_reg <= 8'h00;
         own_reg <= 5'h00;
         strap_done_reg <= 2'h0;
         on_d_reg <= 1'b0;
         card_d_reg <= 1'b0;
         gpio_d_reg <= 1'b0;
         permit_reg <= 1'b0;
      end
      else
      begin
         // Straps are caught once, after synchronisers have settled past reset
         strap_done_reg <= strap_done_reg + {1'b0, ~&strap_done_reg};
         if (strap_done_reg == 2'h2)
            own_reg <= strap_idx[4:0];
         on_d_reg <= on_s;
         card_d_reg <= card_s;
         gpio_d_reg <= gpio_s;
         fault_e_reg <= e_next;
         fault_f_reg <= f_next;
         kind_reg <= kind_next;
         permit_reg <= permit_next;
         if (wr_b)
            alert_en_reg <= {wdata_reg[7:4], asserted_next, wdata_reg[2:0]};
         else
            alert_en_reg[`SSFAC_B_ASSERTED] <= asserted_next;
         if (wr_c)
            ctrl_reg <= wdata_reg;
         if (wr_d)
            on_reg <= wdata_reg;
         if (wr_g)
            gpio_reg <= wdata_reg;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (seq_wr)
         adc_data_reg[adc_channel_o] <= seq_data;
      else if (wr_dat)
         adc_data_reg[dix] <= wdata_reg;
   end

   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_reg <= I2C_IDLE;
         sh_reg <= 8'h00;
         bcnt_reg <= 3'h0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         drv_reg <= 1'b0;
         ara_reg <= 1'b0;
         first_reg <= 1'b0;
         acked_reg <= 1'b0;
         ptr_reg <= 5'h00;
         wr_reg <= 1'b0;
         wdata_reg <= 8'h00;
         ara_win_reg <= 1'b0;
      end
      else
      begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         wr_reg <= 1'b0;
         ara_win_reg <= 1'b0;
         if (scl_rise)
         begin
            sh_reg <= rx_byte;
            bcnt_reg <= bcnt_reg + 3'h1;
         end
         if (start_c)
         begin
            st_reg <= I2C_ADDR;
            bcnt_reg <= 3'h0;
            drv_reg <= 1'b0;
         end
         else if (stop_c)
         begin
            st_reg <= I2C_IDLE;
            drv_reg <= 1'b0;
         end
         else
         begin
            case (st_reg)
               I2C_ADDR:
               begin
                  if (last_bit)
                  begin
                     st_reg <= addr_hit ? I2C_ACK_ADDR : I2C_IDLE;
                     ara_reg <= hit_ara;
                  end
               end
               I2C_ACK_ADDR, I2C_ACK_CMD, I2C_ACK_W:
               begin
                  if (scl_rise)
                     sh_reg <= sh_reg; // Keep the read/write bit through the acknowledge clock
                  if (scl_fall && !drv_reg)
                     drv_reg <= 1'b1;
                  else if (ack_end)
                  begin
                     drv_reg <= 1'b0;
                     bcnt_reg <= 3'h0;
                     if (st_reg == I2C_ACK_ADDR && sh_reg[0])
                     begin
                        st_reg <= I2C_TX;
                        drv_reg <= !tx_byte[7];
                        sh_reg <= {tx_byte[6:0], 1'b1};
                     end
                     else if (st_reg == I2C_ACK_ADDR)
                        st_reg <= I2C_CMD;
                     else
                        st_reg <= I2C_WDATA;
                  end
               end
               I2C_CMD:
               begin
                  if (last_bit)
                  begin
                     ptr_reg <= rx_byte[4:0];
                     first_reg <= 1'b1;
                     st_reg <= I2C_ACK_CMD;
                  end
               end
               I2C_WDATA:
               begin
                  if (last_bit)
                  begin
                     wr_reg <= first_reg;
                     wdata_reg <= rx_byte;
                     first_reg <= 1'b0;
                     st_reg <= I2C_ACK_W;
                  end
               end
               I2C_TX:
               begin
                  if (scl_rise)
                  begin
                     sh_reg <= sh_reg;
                     bcnt_reg <= bcnt_reg; // Sent bits are counted on falling edges only
                  end
                  if (scl_rise && ara_reg && !drv_reg && !sda_s)
                  begin
                     st_reg <= I2C_IDLE;
                     drv_reg <= 1'b0;
                  end
                  else if (scl_fall && bcnt_reg == 3'h7)
                  begin
                     drv_reg <= 1'b0;
                     ara_win_reg <= ara_reg;
                     st_reg <= I2C_RXACK;
                  end
                  else if (scl_fall)
                  begin
                     drv_reg <= !sh_reg[7];
                     sh_reg <= {sh_reg[6:0], 1'b1};
                     bcnt_reg <= bcnt_reg + 3'h1;
                  end
               end
               I2C_RXACK:
               begin
                  if (scl_rise)
                     acked_reg <= !sda_s;
                  if (scl_fall && acked_reg && !ara_reg)
                  begin
                     st_reg <= I2C_TX;
                     bcnt_reg <= 3'h0;
                     drv_reg <= !tx_byte[7];
                     sh_reg <= {tx_byte[6:0], 1'b1};
                  end
                  else if (scl_fall)
                     st_reg <= I2C_IDLE;
               end
               default:
                  drv_reg <= 1'b0;
            endcase
         end
      end
   end

   a_alert_en_reset: assert property (@(posedge core_clk_i)
      $rose(rstn_i) |-> alert_en_reg == 8'h00) else $error("alert enables not clear");
   a_alert_pull: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      alert_raise |=> !alert_oe_n_o) else $error("alert not driven");
   a_on_fall_clr: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      on_fall && set_e == 8'h00 && keep_e == 8'h00 |=> fault_e_reg == 8'h00)
      else $error("turn-on fall did not clear");
   a_uvlo_clr: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      uvlo_s && set_f == 8'h00 && keep_f == 8'h00 |=> fault_f_reg == 8'h00)
      else $error("lockout did not clear");
   a_card_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      card_fall && !uvlo_s && !on_fall && !oc_cool_s
      |=> fault_f_reg[`SSFAC_F_CARD] && fault_e_reg == $past(set_e))
      else $error("card change handling wrong");
   a_fault_keep: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      uv_s[0] |=> fault_e_reg[0]) else $error("active fault cleared");
   a_cool_keep: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      oc_cool_s && fault_e_reg[4] |=> fault_e_reg[4]) else $error("cooldown fault cleared");
   a_switch_off: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      !ctrl_reg[`SSFAC_C_OC_RETRY] && |fault_e_reg[7:4] |=> !switch_permit_o)
      else $error("switches allowed with fault");
endmodule : ssfac_top

// *** src/ssfac_regs.svh ***
`ifndef SSFAC_REGS_SVH
`define SSFAC_REGS_SVH
// How it works
// - Alert enables are all clear after reset; no fault alerts until enabled.
// - A newly set fault kind with its enable set pulls the alert line low.
// - Writing zeros to a fault register clears those bits unless held.
// - Falling edge on the turn-on pin clears both fault registers.
// - Internal supply lockout resets both fault registers.
// - Card-present falling clears all faults but sets the card change flag.
// - A fault whose condition is still active cannot be cleared.
// - Overcurrent and power-good faults stay set through their cool-down.
// - Autoretry restarts never alter fault register contents.
// - Without autoretry, set uv, oc or pgi faults keep the switches off.
// - Free-running converter refreshes thirteen channels every 665 ms.
// - Channel thirteen source is the pin picked by the two select bits.
// - Hold bit stops conversions; quiescent shows busy low, data writable.
// - While quiescent, a channel-select write naming channel 0 to 12 runs one conversion with busy high.
// - Dropping the hold bit resumes cycling from the first channel.
// - Slave supports read byte, write byte, read word and write word.
// - Read word returns the same register again as the second byte.
// - Write word acknowledges and discards the second data byte.
// - Slave address is 01 plus five bits decoded from four straps.
// - Mass-write address accepts writes unless mass write enable is zero.
// - Alert response address is acknowledged only while driving alert low.
// - Command byte low five bits become a pointer kept across transfers.
// - Alert asserted bit reads one while driving; writing zero releases.
// - Alerts rise only on a new fault kind or a recurrence after clear.
`define SSFAC_A_STATUS 5'h00
`define SSFAC_A_ALERT 5'h01
`define SSFAC_A_CTRL 5'h02
`define SSFAC_A_ON 5'h03
`define SSFAC_A_FAULT1 5'h04
`define SSFAC_A_FAULT2 5'h05
`define SSFAC_A_GPIO 5'h06
`define SSFAC_A_CHSEL 5'h07
`define SSFAC_A_DATA0 5'h10
`define SSFAC_ALERT_RST 8'h00
`define SSFAC_CTRL_RST 8'h28
`define SSFAC_C_OC_RETRY 1
`define SSFAC_C_PGI_RETRY 4
`define SSFAC_C_MASS_WR 5
`define SSFAC_C_HOLD 7
`define SSFAC_B_ASSERTED 3
`define SSFAC_F_PGI 4
`define SSFAC_F_CARD 6
`define SSFAC_ADDR_HI 2'h1
`define SSFAC_MASS_ADDR 7'h17
`define SSFAC_ARA_ADDR 7'h0C
`define SSFAC_NUM_CH 13
`define SSFAC_REFRESH_MS 665
`define SSFAC_CLK_KHZ 100000
`define SSFAC_CONV_CYC ((`SSFAC_REFRESH_MS * `SSFAC_CLK_KHZ) / `SSFAC_NUM_CH)
`endif

// *** src/ssfac_pkg.sv ***
package ssfac_pkg;
   typedef enum logic [3:0] {
      I2C_IDLE = 4'h0, I2C_ADDR = 4'h1, I2C_ACK_ADDR = 4'h2, I2C_CMD = 4'h3,
      I2C_ACK_CMD = 4'h4, I2C_WDATA = 4'h5, I2C_ACK_W = 4'h6, I2C_TX = 4'h7,
      I2C_RXACK = 4'h8
   } ssfac_i2c_e;
   typedef enum logic [1:0] {
      SEQ_RUN = 2'h0, SEQ_QUIET = 2'h1, SEQ_ONE = 2'h2
   } ssfac_seq_e;
endpackage : ssfac_pkg

// *** src/ssfac_sync.sv ***
module ssfac_sync #(
   parameter int W = 1
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         meta_reg <= '0;
         q_o <= '0;
      end
      else
      begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule : ssfac_sync

// *** src/ssfac_adc_seq.sv ***
`include "ssfac_regs.svh"
module ssfac_adc_seq
   import ssfac_pkg::*;
#(
   parameter int CONV_CYC = `SSFAC_CONV_CYC,
   parameter int NCH = `SSFAC_NUM_CH
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic hold_i,
   input wire logic start_i,
   input wire logic [3:0] start_ch_i,
   input wire logic [7:0] result_i,
   output logic [3:0] chan_o,
   output logic wr_o,
   output logic [7:0] wr_data_o,
   output logic busy_o
);
   localparam int CW = $clog2(CONV_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(CONV_CYC - 1);
   localparam logic [3:0] CH_LAST = 4'(NCH - 1);
   ssfac_seq_e st_reg;
   logic [CW-1:0] cnt_reg;
   wire done = (cnt_reg == LAST);
   wire start_ok = start_i && (start_ch_i <= CH_LAST);
   assign busy_o = (st_reg != SEQ_QUIET);
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         st_reg <= SEQ_RUN;
         cnt_reg <= '0;
         chan_o <= 4'h0;
         wr_o <= 1'b0;
         wr_data_o <= 8'h00;
      end
      else
      begin
         wr_o <= 1'b0;
         cnt_reg <= done ? '0 : cnt_reg + 1'b1;
         case (st_reg)
            SEQ_RUN:
            begin
               if (hold_i)
               begin
                  st_reg <= SEQ_QUIET;
                  cnt_reg <= '0;
               end
               else if (done)
               begin
                  wr_o <= 1'b1;
                  wr_data_o <= result_i;
               end
               // Advance after the write, which lands at the channel still shown
               else if (wr_o)
                  chan_o <= (chan_o == CH_LAST) ? 4'h0 : chan_o + 4'h1;
            end
            SEQ_QUIET:
            begin
               cnt_reg <= '0;
               if (!hold_i)
               begin
                  st_reg <= SEQ_RUN;
                  chan_o <= 4'h0;
               end
               else if (start_ok)
               begin
                  st_reg <= SEQ_ONE;
                  chan_o <= start_ch_i;
               end
            end
            SEQ_ONE:
            begin
               if (done)
               begin
                  wr_o <= 1'b1;
                  wr_data_o <= result_i;
                  st_reg <= SEQ_QUIET;
               end
            end
            default:
               st_reg <= SEQ_QUIET;
         endcase
      end
   end
   a_hold_quiet: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      hold_i && st_reg == SEQ_RUN |=> !busy_o) else $error("hold did not quiet");
   a_resume_first: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      st_reg == SEQ_QUIET && !hold_i |=> busy_o && chan_o == 4'h0) else $error("bad resume");
   a_bad_chan: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
      st_reg == SEQ_QUIET && hold_i && start_i && start_ch_i > CH_LAST |=> !busy_o && !wr_o)
      else $error("bad channel started");
endmodule : ssfac_adc_seq

// *** tb/ssfac_master.sv ***
module ssfac_master (
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic bit_io(input logic b, output logic r);
      sda_low_o = !b;
      #40 scl_o = 1'b1;
      #40 r = sda_i;
      #40 scl_o = 1'b0;
      #40;
   endtask : bit_io
   // Also serves as repeated start, entered with the clock low
   task automatic start();
      sda_low_o = 1'b0;
      #40 scl_o = 1'b1;
      #80 sda_low_o = 1'b1;
      #80 scl_o = 1'b0;
   endtask : start
   task automatic stop();
      sda_low_o = 1'b1;
      #40 scl_o = 1'b1;
      #80 sda_low_o = 1'b0;
      #80;
   endtask : stop
   task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(ack_in, ack);
   endtask : byte_io
   task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1,
                     input int n, output logic nak);
      logic [7:0] q;
      logic k;
      start();
      byte_io({a, 1'b0}, 1'b1, q, nak);
      byte_io(c, 1'b1, q, k);
      byte_io(d0, 1'b1, q, k);
      if (n > 1)
         byte_io(d1, 1'b1, q, k);
      stop();
   endtask : wr
   task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [7:0] q0, output logic [7:0] q1);
      logic k;
      start();
      byte_io({a, 1'b0}, 1'b1, q0, k);
      byte_io(c, 1'b1, q0, k);
      start();
      byte_io({a, 1'b1}, 1'b1, q0, k);
      byte_io(8'hFF, 1'b0, q0, k);
      byte_io(8'hFF, 1'b1, q1, k);
      stop();
   endtask : rd
endmodule : ssfac_master

// *** tb/tb_ssfac_top.sv ***
module tb_ssfac_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int CC = 20;
   localparam logic [6:0] DA = 7'h20;
   logic core_clk_i, rstn_i, on_pin, card_n, uvlo, scl, m_low, sda_oe_n, al_oe_n, permit, nak;
   logic [3:0] uv, oc, pb, ch;
   logic gpio1, downstream_good_input, ocool, pcool;
   logic [1:0] gsel;
   logic [7:0] res, q0, q1;
   int miscompares = 0;
   int checks_done = 0;
   // Pull-up wins unless either party pulls low
   wire logic sda = !(m_low || !sda_oe_n);
   ssfac_master m (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
   ssfac_top #(.CONV_CYC(CC)) dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda),
      .sda_out_o(), .sda_oe_n_o(sda_oe_n), .alert_out_o(), .alert_oe_n_o(al_oe_n), .on_pin_i(on_pin),
      .card_present_n_i(card_n), .internal_supply_uvlo_i(uvlo), .gpio1_i(gpio1), .uv_cond_i(uv),
      .oc_cond_i(oc), .pb_cond_i(pb), .pgi_cond_i(downstream_good_input), .fet_short_cond_i(1'b0), .oc_cooldown_i(ocool),
      .pgi_cooldown_i(pcool), .addr_strap_0_i(1'b0), .addr_strap_1_i(1'b0), .addr_strap_2_i(2'h0),
      .addr_strap_3_i(2'h0), .adc_result_i(res | {4'h0, ch}), .adc_channel_o(ch), .adc_gpio_sel_o(gsel),
      .switch_permit_o(permit));
   initial
   begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : tick
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop
   task automatic t_reset();
      chk({7'h0, al_oe_n}, 8'h01);
      m.rd(DA, 8'h01, q0, q1);
      chk(q0, 8'h00);
      m.rd(DA, 8'h02, q0, q1);
      chk(q0, 8'h28);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_word();
      m.wr(DA, 8'hE3, 8'hA5, 8'h5A, 2, nak);
      chk({7'h0, nak}, 8'h00);
      m.rd(DA, 8'h03, q0, q1);
      chk(q0, 8'hA5);
      chk(q1, 8'hA5);
      $display("t_word done");
   endtask : t_word
   task automatic t_fault();
      m.wr(DA, 8'h01, 8'h01, 8'h00, 1, nak);
      uv = 4'h1;
      oc = 4'h1;
      tick(10);
      uv = 4'h0;
      oc = 4'h0;
      tick(4);
      chk({7'h0, permit}, 8'h00);
      chk({7'h0, al_oe_n}, 8'h00);
      m.rd(DA, 8'h01, q0, q1);
      chk(q0, 8'h09);
      m.wr(DA, 8'h01, 8'h01, 8'h00, 1, nak);
      chk({7'h0, al_oe_n}, 8'h01);
      m.wr(DA, 8'h04, 8'h00, 8'h00, 1, nak);
      m.rd(DA, 8'h04, q0, q1);
      chk(q0, 8'h00);
      tick(4);
      chk({7'h0, permit}, 8'h01);
      uv = 4'h1;
      tick(5);
      chk({7'h0, al_oe_n}, 8'h00);
      m.wr(DA, 8'h04, 8'h00, 8'h00, 1, nak);
      m.rd(DA, 8'h04, q0, q1);
      chk(q0, 8'h01);
      uv = 4'h0;
      oc = 4'h2;
      ocool = 1'b1;
      tick(5);
      oc = 4'h0;
      m.wr(DA, 8'h04, 8'h00, 8'h00, 1, nak);
      m.rd(DA, 8'h04, q0, q1);
      chk(q0, 8'h20);
      ocool = 1'b0;
      $display("t_fault done");
   endtask : t_fault
   task automatic t_clear();
      on_pin = 1'b0;
      tick(5);
      m.rd(DA, 8'h04, q0, q1);
      chk(q0, 8'h00);
      uv = 4'h2;
      tick(5);
      uv = 4'h0;
      uvlo = 1'b1;
      tick(5);
      uvlo = 1'b0;
      tick(2);
      m.rd(DA, 8'h04, q0, q1);
      chk(q0, 8'h00);
      card_n = 1'b1;
      tick(5);
      card_n = 1'b0;
      tick(5);
      m.rd(DA, 8'h05, q0, q1);
      chk(q0, 8'h40);
      downstream_good_input = 1'b1;
      tick(5);
      downstream_good_input = 1'b0;
      tick(4);
      chk({7'h0, permit}, 8'h00);
      $display("t_clear done");
   endtask : t_clear
   task automatic t_addr();
      m.wr(7'h21, 8'h03, 8'h11, 8'h00, 1, nak);
      chk({7'h0, nak}, 8'h01);
      m.wr(7'h17, 8'h03, 8'h3C, 8'h00, 1, nak);
      chk({7'h0, nak}, 8'h00);
      m.rd(DA, 8'h03, q0, q1);
      chk(q0, 8'h3C);
      $display("t_addr done");
   endtask : t_addr
   task automatic t_adc();
      // Free-run results carry the channel number, so a misplaced write shows
      m.rd(DA, 8'h1C, q0, q1);
      chk(q0, 8'h0C);
      m.wr(DA, 8'h06, 8'hC0, 8'h00, 1, nak);
      chk({6'h0, gsel}, 8'h03);
      m.wr(DA, 8'h02, 8'hA8, 8'h00, 1, nak);
      tick(2 * CC);
      m.rd(DA, 8'h00, q0, q1);
      chk({7'h0, q0[7]}, 8'h00);
      res = 8'h77;
      m.wr(DA, 8'h07, 8'h05, 8'h00, 1, nak);
      m.rd(DA, 8'h15, q0, q1);
      chk(q0, 8'h77);
      m.wr(DA, 8'h07, 8'h0D, 8'h00, 1, nak);
      m.rd(DA, 8'h15, q0, q1);
      chk(q0, 8'h77);
      m.rd(DA, 8'h00, q0, q1);
      chk({7'h0, q0[7]}, 8'h00);
      m.wr(DA, 8'h02, 8'h28, 8'h00, 1, nak);
      m.rd(DA, 8'h00, q0, q1);
      chk({7'h0, q0[7]}, 8'h01);
      $display("t_adc done");
   endtask : t_adc
   initial
   begin
      rstn_i = 1'b0;
      on_pin = 1'b1;
      card_n = 1'b0;
      uvlo = 1'b0;
      uv = 4'h0;
      oc = 4'h0;
      pb = 4'h0;
      gpio1 = 1'b0;
      downstream_good_input = 1'b0;
      ocool = 1'b0;
      pcool = 1'b0;
      res = 8'h00;
      tick(5);
      rstn_i = 1'b1;
      tick(4);
      t_reset();
      t_word();
      t_fault();
      t_clear();
      t_addr();
      t_adc();
      report_and_stop();
   end
   initial
   begin
      repeat (100000) @(posedge core_clk_i);
      miscompares++;
      report_and_stop();
   end
endmodule : tb_ssfac_top
